// ===== rtl/mdfs_map.svh
// Register offsets, field positions and reset values of the motion
// delta and frame statistics register group.
// Assumes it is included by bare name from the modules.
`ifndef MDFS_MAP_SVH
`define MDFS_MAP_SVH

// ==========================================================
// Register offsets
`define MDFS_ADDR_STATUS 7'h02
`define MDFS_ADDR_X_LOW 7'h03
`define MDFS_ADDR_X_HIGH 7'h04
`define MDFS_ADDR_Y_LOW 7'h05
`define MDFS_ADDR_Y_HIGH 7'h06
`define MDFS_ADDR_FEATURE 7'h07
`define MDFS_ADDR_INTENSITY 7'h08
`define MDFS_ADDR_BRIGHT 7'h09
`define MDFS_ADDR_DARK 7'h0A
`define MDFS_ADDR_EXPOSURE_LOW 7'h0B

// ==========================================================
// Field positions and limits
`define MDFS_MOTION_BIT 7
`define MDFS_FEATURE_LSB 2
`define MDFS_INTENSITY_LSB 9
`define MDFS_FEATURE_MAX 8'hA9
`define MDFS_INTENSITY_MAX 8'hDF
`define MDFS_STEP_W 8

// ==========================================================
// Reset values
`define MDFS_RST_MOTION 8'h00
`define MDFS_RST_STATS 8'h00
`define MDFS_RST_EXPOSURE_LOW 8'h20

`endif

// ===== rtl/mdfs_pkg.sv
// Types shared by the motion delta and frame statistics registers.
// Assumes nothing of its surroundings.
package mdfs_pkg;
  // ==========================================================
  // Types
  typedef logic [7:0] mdfs_byte_type;   // One register value
  typedef logic [15:0] mdfs_word_type;  // One axis displacement
endpackage

// ===== rtl/mdfs_axis_accum.sv
// One axis of motion: saturating accumulator, frozen sample, byte reads.
// Assumes freeze and byte reads never come in the same cycle.
`timescale 1ns/10ps
`include "mdfs_map.svh"
`default_nettype none
module mdfs_axis_accum
  import mdfs_pkg::*;
#(
  parameter int STEP_W = `MDFS_STEP_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic step_valid,
  input wire logic [STEP_W-1:0] step,
  input wire logic freeze,
  input wire logic read_low,
  input wire logic read_high,
  output mdfs_byte_type low_byte,
  output mdfs_byte_type high_byte,
  output logic moved
);
  // ==========================================================
  // State
  mdfs_word_type acc;        // Live motion since last report
  mdfs_word_type hold;       // Captured sample for byte reads
  logic held;                // Low byte of hold is the one to read
  mdfs_word_type next_acc;
  mdfs_word_type next_hold;
  logic next_held;
  logic next_moved;
  logic [16:0] sum;          // One bit wider to see overflow
  mdfs_word_type step_word;  // Step after sign extension
  mdfs_word_type fresh;      // What acc restarts from after a capture

  // Saturate rather than wrap, so a long swipe never flips sign
  function automatic mdfs_word_type sat16(input logic [16:0] s);
    if (s[16] != s[15]) begin
      sat16 = {s[16], {15{~s[16]}}};
    end else begin
      sat16 = s[15:0];
    end
  endfunction

  // Low byte comes from the sample if frozen, else straight from acc
  assign low_byte = held ? hold[7:0] : acc[7:0];
  assign high_byte = hold[15:8];

  // ==========================================================
  // Next state
  always_comb begin
    step_word = {{(16-STEP_W){step[STEP_W-1]}}, step};
    fresh = step_valid ? step_word : 16'h0000;
    sum = {acc[15], acc} + {step_word[15], step_word};
    next_acc = acc;
    next_hold = hold;
    next_held = held;
    if (freeze) begin
      // Status read freezes the sample; motion keeps counting in acc
      next_hold = acc;
      next_held = 1'b1;
      next_acc = fresh;
    end else if (read_low && !held) begin
      // No freeze first: take the live value, both halves at once
      next_hold = {acc[15:8], 8'h00};
      next_acc = fresh;
    end else begin
      if (step_valid) begin
        next_acc = sat16(sum);
      end
      if (read_low) begin
        // Frozen low byte is handed out and cleared
        next_hold[7:0] = 8'h00;
        next_held = 1'b0;
      end
    end
    if (read_high) begin
      // High half was captured by the freeze or a live low read; reading clears it
      next_hold[15:8] = 8'h00;
    end
    // New motion in the clearing cycle keeps the flag up
    next_moved = (moved && !freeze) ||
                 (step_valid && step != '0);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc <= 16'h0000;
      hold <= 16'h0000;
      held <= 1'b0;
      moved <= 1'b0;
    end else begin
      acc <= next_acc;
      hold <= next_hold;
      held <= next_held;
      moved <= next_moved;
    end
  end

  // ==========================================================
  // Checks
  // Helper: the upper half that the next high read owes, and whether
  // one is still owed; a counter of gaps would not bound the wait
  logic pair_open;
  logic next_pair_open;
  mdfs_byte_type pair_high;
  mdfs_byte_type next_pair_high;

  // A freeze or a live low read promises a half; a high read pays it
  always_comb begin
    next_pair_open = pair_open;
    next_pair_high = pair_high;
    if (freeze || (read_low && !held)) begin
      next_pair_open = 1'b1;
      next_pair_high = acc[15:8];
    end else if (read_high) begin
      next_pair_open = 1'b0;
    end
  end

  // Helper registers, reset to nothing owed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pair_open <= 1'b0;
      pair_high <= 8'h00;
    end else begin
      pair_open <= next_pair_open;
      pair_high <= next_pair_high;
    end
  end

  sequence live_low_read_s;
    read_low && !held && !freeze;
  endsequence

  sequence high_read_s;
    read_high && !read_low && !freeze;
  endsequence

  high_pairs_low_a: assert property (@(posedge clock)
    disable iff (rst)
    high_read_s ##0 pair_open |-> high_byte == pair_high)
    else $error("high byte not from the low read sample");

  low_capture_a: assert property (@(posedge clock)
    disable iff (rst)
    live_low_read_s |=> high_byte == $past(acc[15:8]) &&
    acc == $past(fresh))
    else $error("low read did not capture the sample");

  high_clear_a: assert property (@(posedge clock)
    disable iff (rst)
    high_read_s |=> high_byte == 8'h00)
    else $error("high byte not cleared by read");

  frozen_clear_a: assert property (@(posedge clock)
    disable iff (rst)
    read_low && held && !freeze |=> !held && hold[7:0] == 8'h00)
    else $error("frozen low byte not cleared by read");

  freeze_hold_a: assert property (@(posedge clock)
    disable iff (rst)
    freeze |=> held && hold == $past(acc))
    else $error("freeze did not capture the accumulator");

  flag_set_a: assert property (@(posedge clock)
    disable iff (rst)
    step_valid && step != '0 |=> moved)
    else $error("motion flag missed a step");

  sat_floor_a: assert property (@(posedge clock)
    disable iff (rst)
    acc == 16'h8000 && step_valid && step[STEP_W-1] && !freeze &&
    !read_low |=> acc == 16'h8000)
    else $error("accumulator wrapped below the floor");

  sat_ceiling_a: assert property (@(posedge clock)
    disable iff (rst)
    acc == 16'h7FFF && step_valid && !step[STEP_W-1] && !freeze &&
    !read_low |=> acc == 16'h7FFF)
    else $error("accumulator wrapped above the ceiling");
endmodule
`default_nettype wire

// ===== rtl/mdfs_regs.sv
// Top of the motion delta and frame statistics register group.
// Assumes the serial port decoder gives a one-cycle read strobe with
// a seven-bit address, and the image engine gives per-frame results.
`timescale 1ns/10ps
`include "mdfs_map.svh"
`default_nettype none
module mdfs_regs
  import mdfs_pkg::*;
#(
  parameter int STEP_W = `MDFS_STEP_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic step_valid,
  input wire logic [STEP_W-1:0] step_x,
  input wire logic [STEP_W-1:0] step_y,
  input wire logic frame_done,
  input wire logic [9:0] feature_total,
  input wire logic [16:0] pixel_total,
  input wire logic [6:0] pixel_max,
  input wire logic [6:0] pixel_min,
  input wire logic [15:0] exposure_count,
  input wire logic rd_strobe,
  input wire logic [6:0] rd_addr,
  output mdfs_byte_type rd_data,
  output logic rd_valid,
  output logic motion_seen_flag
);
  // ==========================================================
  // Declarations
  localparam mdfs_byte_type FEAT_MAX = `MDFS_FEATURE_MAX;
  localparam mdfs_byte_type SUM_MAX = `MDFS_INTENSITY_MAX;

  mdfs_byte_type feature_count;      // Features divided by four
  mdfs_byte_type intensity_sum;      // Pixel sum divided by 512
  mdfs_byte_type brightest_value;    // Frame maximum pixel
  mdfs_byte_type darkest_value;      // Frame minimum pixel
  mdfs_byte_type exposure_time_low;  // Exposure count, low byte
  mdfs_byte_type next_feature_count;
  mdfs_byte_type next_intensity_sum;
  mdfs_byte_type next_brightest_value;
  mdfs_byte_type next_darkest_value;
  mdfs_byte_type next_exposure_time_low;
  mdfs_byte_type next_rd_data;
  logic next_rd_valid;
  logic next_motion_seen_flag;

  logic [1:0] axis_valid;            // Per axis step valid
  logic [STEP_W-1:0] axis_step [2];  // Per axis step
  logic [1:0] axis_low_rd;           // Per axis low byte read
  logic [1:0] axis_high_rd;          // Per axis high byte read
  mdfs_byte_type axis_low [2];       // Per axis low byte
  mdfs_byte_type axis_high [2];      // Per axis high byte
  logic [1:0] axis_moved;            // Per axis motion flag
  logic status_rd;                   // Status read freezes both axes

  // ==========================================================
  // Read decode
  assign status_rd = rd_strobe && rd_addr == `MDFS_ADDR_STATUS;
  assign axis_valid = {step_valid, step_valid};
  assign axis_step[0] = step_x;
  assign axis_step[1] = step_y;
  assign axis_low_rd[0] = rd_strobe && rd_addr == `MDFS_ADDR_X_LOW;
  assign axis_low_rd[1] = rd_strobe && rd_addr == `MDFS_ADDR_Y_LOW;
  assign axis_high_rd[0] = rd_strobe && rd_addr == `MDFS_ADDR_X_HIGH;
  assign axis_high_rd[1] = rd_strobe && rd_addr == `MDFS_ADDR_Y_HIGH;

  // ==========================================================
  // Axes, one accumulator each
  for (genvar i = 0; i < 2; i++) begin : g_axis
    mdfs_axis_accum #(
      .STEP_W(STEP_W)
    ) u_axis (
      .clock(clock),
      .rst(rst),
      .step_valid(axis_valid[i]),
      .step(axis_step[i]),
      .freeze(status_rd),
      .read_low(axis_low_rd[i]),
      .read_high(axis_high_rd[i]),
      .low_byte(axis_low[i]),
      .high_byte(axis_high[i]),
      .moved(axis_moved[i])
    );
  end

  // ==========================================================
  // Frame statistics and read data, next values
  always_comb begin
    next_feature_count = feature_count;
    next_intensity_sum = intensity_sum;
    next_brightest_value = brightest_value;
    next_darkest_value = darkest_value;
    next_exposure_time_low = exposure_time_low;
    if (frame_done) begin
      // Clamp rather than trust the engine never to overshoot
      if (feature_total[9:`MDFS_FEATURE_LSB] > FEAT_MAX) begin
        next_feature_count = FEAT_MAX;
      end else begin
        next_feature_count = feature_total[9:`MDFS_FEATURE_LSB];
      end
      if (pixel_total[16:`MDFS_INTENSITY_LSB] > SUM_MAX) begin
        next_intensity_sum = SUM_MAX;
      end else begin
        next_intensity_sum = pixel_total[16:`MDFS_INTENSITY_LSB];
      end
      next_brightest_value = {1'b0, pixel_max};
      next_darkest_value = {1'b0, pixel_min};
      // Only the low byte lives here; the high byte is elsewhere
      next_exposure_time_low = exposure_count[7:0];
    end
    next_motion_seen_flag = |axis_moved;
    next_rd_valid = rd_strobe;
    next_rd_data = 8'h00;
    if (rd_strobe) begin
      // Value answered is the one before any read clear takes effect
      unique case (rd_addr)
        `MDFS_ADDR_STATUS: next_rd_data = {|axis_moved, 7'h00};
        `MDFS_ADDR_X_LOW: next_rd_data = axis_low[0];
        `MDFS_ADDR_X_HIGH: next_rd_data = axis_high[0];
        `MDFS_ADDR_Y_LOW: next_rd_data = axis_low[1];
        `MDFS_ADDR_Y_HIGH: next_rd_data = axis_high[1];
        `MDFS_ADDR_FEATURE: next_rd_data = feature_count;
        `MDFS_ADDR_INTENSITY: next_rd_data = intensity_sum;
        `MDFS_ADDR_BRIGHT: next_rd_data = brightest_value;
        `MDFS_ADDR_DARK: next_rd_data = darkest_value;
        `MDFS_ADDR_EXPOSURE_LOW: next_rd_data = exposure_time_low;
        // Unmapped addresses answer zero
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      feature_count <= `MDFS_RST_STATS;
      intensity_sum <= `MDFS_RST_STATS;
      brightest_value <= `MDFS_RST_STATS;
      darkest_value <= `MDFS_RST_STATS;
      exposure_time_low <= `MDFS_RST_EXPOSURE_LOW;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      motion_seen_flag <= 1'b0;
    end else begin
      feature_count <= next_feature_count;
      intensity_sum <= next_intensity_sum;
      brightest_value <= next_brightest_value;
      darkest_value <= next_darkest_value;
      exposure_time_low <= next_exposure_time_low;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      motion_seen_flag <= next_motion_seen_flag;
    end
  end

  // ==========================================================
  // Checks
  sequence x_low_read_s;
    rd_strobe && rd_addr == `MDFS_ADDR_X_LOW;
  endsequence

  // No step now and no motion since the last freeze: the axis is zero,
  // so whatever the low byte shows after the read must be zero too
  sequence x_quiet_s;
    !step_valid && !axis_moved[0];
  endsequence

  sequence y_low_read_s;
    rd_strobe && rd_addr == `MDFS_ADDR_Y_LOW;
  endsequence

  sequence y_quiet_s;
    !step_valid && !axis_moved[1];
  endsequence

  // Status read with no step beside it, so the set cannot win
  sequence status_quiet_s;
    status_rd && !step_valid;
  endsequence

  read_answer_a: assert property (@(posedge clock) disable iff (rst)
    rd_strobe |=> rd_valid ##1 (rd_valid == $past(rd_strobe)))
    else $error("read strobe not answered next cycle");

  // The answer stands one cycle; an idle port rests at zero
  idle_zero_a: assert property (@(posedge clock) disable iff (rst)
    !rd_strobe |=> !rd_valid && rd_data == 8'h00)
    else $error("read port not at rest after an idle cycle");

  x_low_clear_a: assert property (@(posedge clock)
    disable iff (rst)
    x_low_read_s ##0 x_quiet_s |=> axis_low[0] == 8'h00)
    else $error("x low byte not cleared by read");

  y_low_clear_a: assert property (@(posedge clock)
    disable iff (rst)
    y_low_read_s ##0 y_quiet_s |=> axis_low[1] == 8'h00)
    else $error("y low byte not cleared by read");

  feature_cap_a: assert property (@(posedge clock)
    disable iff (rst)
    feature_count <= FEAT_MAX)
    else $error("feature register above its ceiling");

  feature_load_a: assert property (@(posedge clock)
    disable iff (rst)
    frame_done && feature_total[9:2] <= FEAT_MAX
    |=> feature_count == $past(feature_total[9:2]))
    else $error("feature register not loaded from frame");

  intensity_cap_a: assert property (@(posedge clock)
    disable iff (rst)
    frame_done |=> intensity_sum <= SUM_MAX &&
    (intensity_sum == $past(pixel_total[16:9]) ||
     intensity_sum == SUM_MAX))
    else $error("intensity register wrong after frame");

  pixel_range_a: assert property (@(posedge clock)
    disable iff (rst)
    !brightest_value[7] && !darkest_value[7])
    else $error("pixel extreme above seven bits");

  extremes_load_a: assert property (@(posedge clock)
    disable iff (rst)
    frame_done |=> brightest_value == {1'b0, $past(pixel_max)} &&
    darkest_value == {1'b0, $past(pixel_min)})
    else $error("pixel extremes not loaded from frame");

  flag_follow_a: assert property (@(posedge clock)
    disable iff (rst)
    step_valid && (step_x != '0 || step_y != '0) |-> ##2
    motion_seen_flag)
    else $error("motion flag did not follow a step");

  // Flag lags the axis flags by one cycle, hence two cycles here
  flag_clear_a: assert property (@(posedge clock)
    disable iff (rst)
    status_quiet_s |-> ##2 !motion_seen_flag)
    else $error("motion flag not cleared by status read");
endmodule
`default_nettype wire

// ===== verification/mdfs_reader_model.sv
// Model of the microcontroller that reads the motion registers.
// Assumes a one-cycle read strobe answered one cycle later.
`timescale 1ns/10ps
`include "mdfs_map.svh"
`default_nettype none
module mdfs_reader_model
  import mdfs_pkg::*;
(
  input wire logic clock,
  output logic rd_strobe,
  output logic [6:0] rd_addr,
  input wire mdfs_byte_type rd_data,
  input wire logic rd_valid
);
  // ==========================================================
  // Read port
  // Idle port state
  initial begin
    rd_strobe = 1'b0;
    rd_addr = 7'h7F;
  end

  // One read; once idle the address turns to its inverse, so a
  // design that samples late sees a wrong place, not the old one
  task automatic read(input logic [6:0] a, output mdfs_byte_type d);
    int n;
    @(negedge clock);
    rd_strobe = 1'b1;
    rd_addr = a;
    @(negedge clock);
    rd_strobe = 1'b0;
    rd_addr = ~a;
    n = 0;
    // Bounded wait for the answer
    while (rd_valid !== 1'b1 && n < 4) begin
      n++;
      @(negedge clock);
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask

  // Status first to freeze both axes
  // Low byte before high byte of each axis
  // Single consecutive accesses, nothing in between
  task automatic motion(output mdfs_word_type x,
                        output mdfs_word_type y,
                        output mdfs_byte_type st);
    read(`MDFS_ADDR_STATUS, st);
    read(`MDFS_ADDR_X_LOW, x[7:0]);
    read(`MDFS_ADDR_X_HIGH, x[15:8]);
    read(`MDFS_ADDR_Y_LOW, y[7:0]);
    read(`MDFS_ADDR_Y_HIGH, y[15:8]);
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the motion and frame statistics registers.
// Assumes the reader model drives the read port.
`timescale 1ns/10ps
`include "mdfs_map.svh"
`default_nettype none
module testbench;
  import mdfs_pkg::*;
  // ==========================================================
  // Signals
  logic clock, rst, step_valid, frame_done, rd_strobe, rd_valid;
  logic motion_seen_flag;
  logic [7:0] step_x, step_y;
  logic [9:0] feature_total;
  logic [16:0] pixel_total;
  logic [6:0] pixel_max, pixel_min, rd_addr;
  logic [15:0] exposure_count;
  mdfs_byte_type rd_data;
  int fail_count = 0;
  int checks_done = 0;

  // ==========================================================
  // Instances
  mdfs_regs u_mdfs_regs (.clock(clock), .rst(rst),
    .step_valid(step_valid), .step_x(step_x), .step_y(step_y),
    .frame_done(frame_done), .feature_total(feature_total),
    .pixel_total(pixel_total), .pixel_max(pixel_max),
    .pixel_min(pixel_min), .exposure_count(exposure_count),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .motion_seen_flag(motion_seen_flag));
  mdfs_reader_model u_reader (.clock(clock), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  // 250 MHz clock
  initial clock = 1'b0;
  always #2 clock = ~clock;

  // ==========================================================
  // Helpers
  task automatic check(input mdfs_byte_type seen, input mdfs_byte_type exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Whole word compared as two bytes
  task automatic check_word(input mdfs_word_type s, input mdfs_word_type e);
    check(s[7:0], e[7:0]);
    check(s[15:8], e[15:8]);
  endtask

  // Motion flag seen as a byte so it shares the compare
  task automatic check_flag(input logic e);
    check({7'h00, motion_seen_flag}, {7'h00, e});
  endtask

  // Step held for n consecutive edges
  task automatic step(input logic [7:0] sx, input logic [7:0] sy, int n);
    @(negedge clock);
    step_valid = 1'b1;
    step_x = sx;
    step_y = sy;
    repeat (n) @(negedge clock);
    step_valid = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  // Every place reads its reset value, unmapped place reads zero
  task automatic t_reset;
    mdfs_byte_type d;
    for (int a = 2; a <= 10; a++) begin
      u_reader.read(a[6:0], d);
      check(d, `MDFS_RST_STATS);
    end
    u_reader.read(`MDFS_ADDR_EXPOSURE_LOW, d);
    check(d, `MDFS_RST_EXPOSURE_LOW);
    u_reader.read(7'h7F, d);
    check(d, 8'h00);
  endtask

  // Two steps summed, negative Y, then everything cleared
  task automatic t_motion;
    mdfs_word_type x, y;
    mdfs_byte_type st;
    step(8'h03, 8'hFF, 1);
    step(8'h02, 8'hFF, 1);
    repeat (2) @(negedge clock);
    check_flag(1'b1);
    u_reader.motion(x, y, st);
    check(st, 8'h80);
    check_word(x, 16'h0005);
    check_word(y, 16'hFFFE);
    check_flag(1'b0);
    u_reader.motion(x, y, st);
    check(st, 8'h00);
    check_word(x, 16'h0000);
    check_word(y, 16'h0000);
  endtask

  // Both ends of the 16-bit range
  task automatic t_saturate;
    mdfs_word_type x, y;
    mdfs_byte_type st;
    step(8'h7F, 8'h80, 259);
    u_reader.motion(x, y, st);
    check_word(x, 16'h7FFF);
    check_word(y, 16'h8000);
  endtask

  // Low read captures; later steps must not reach the high byte
  task automatic t_pairing;
    mdfs_byte_type d;
    step(8'h7F, 8'h00, 2);
    step(8'h04, 8'h00, 1);
    u_reader.read(`MDFS_ADDR_X_LOW, d);
    check(d, 8'h02);
    step(8'h7F, 8'h00, 3);
    u_reader.read(`MDFS_ADDR_X_HIGH, d);
    check(d, 8'h01);
    u_reader.read(`MDFS_ADDR_X_HIGH, d);
    check(d, 8'h00);
    u_reader.read(`MDFS_ADDR_X_LOW, d);
    check(d, 8'h7D);
    u_reader.read(`MDFS_ADDR_X_HIGH, d);
    check(d, 8'h01);
  endtask

  // One frame of results, expectations from the scaling and clamps
  task automatic t_frame(input logic [9:0] ft, input logic [16:0] pt,
                         input logic [6:0] mx, input logic [6:0] mn,
                         input logic [15:0] ex);
    mdfs_byte_type d, f, s;
    f = ft[9:2];
    if (f > `MDFS_FEATURE_MAX) f = `MDFS_FEATURE_MAX;
    s = pt[16:9];
    if (s > `MDFS_INTENSITY_MAX) s = `MDFS_INTENSITY_MAX;
    @(negedge clock);
    frame_done = 1'b1;
    feature_total = ft;
    pixel_total = pt;
    pixel_max = mx;
    pixel_min = mn;
    exposure_count = ex;
    @(negedge clock);
    frame_done = 1'b0;
    u_reader.read(`MDFS_ADDR_FEATURE, d);
    check(d, f);
    u_reader.read(`MDFS_ADDR_INTENSITY, d);
    check(d, s);
    u_reader.read(`MDFS_ADDR_BRIGHT, d);
    check(d, {1'b0, mx});
    u_reader.read(`MDFS_ADDR_DARK, d);
    check(d, {1'b0, mn});
    u_reader.read(`MDFS_ADDR_EXPOSURE_LOW, d);
    check(d, ex[7:0]);
  endtask

  // ==========================================================
  // Verdict
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    step_valid = 1'b0;
    step_x = 8'h00;
    step_y = 8'h00;
    frame_done = 1'b0;
    feature_total = 10'h000;
    pixel_total = 17'h00000;
    pixel_max = 7'h00;
    pixel_min = 7'h00;
    exposure_count = 16'h0000;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    t_reset;
    t_motion;
    t_saturate;
    t_pairing;
    t_frame(10'h3FF, 17'h1FFFF, 7'h7F, 7'h00, 16'h1234);
    t_frame(10'h2A4, 17'h1BE00, 7'h00, 7'h7F, 16'h00FF);
    t_frame(10'h0A5, 17'h0A5FF, 7'h41, 7'h05, 16'hABCD);
    close_out;
  end

  // Watchdog, about thirteen times the expected run
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
